// ---- hw/pnp_config_bank.sv ----
// plug-and-play configuration register bank behind index and data ports
`timescale 1ns/100ps
`default_nettype none

module pnp_config_bank
	import pnp_cfg_pkg::*;
#(
	parameter logic [7:0] CHIP_ID = 8'h5A, // arbitrary value
	parameter logic [7:0] CHIP_REV = 8'h01, // arbitrary value
	parameter int NUM_REGS = NREG
)
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic host_bus_reset_n,
	input wire logic main_supply_power_on_reset,
	input wire logic standby_supply_power_on_reset,
	input wire logic numbering_strap,
	input wire io_req_s io_req,
	output io_rsp_s io_rsp,
	output logic config_mode,
	output logic device_numbering_select,
	output logic [15:0] cfg_port_base,
	output logic [15:0] floppy_base,
	output logic [15:0] parport_base,
	output logic floppy_active,
	output logic parport_active
);

	// ----------------------------------------------------------------
	// elaboration check
	// ----------------------------------------------------------------
	generate
		if (NUM_REGS != NREG)
		begin : g_bad_size
			$error("register count must match the table");
		end
	endgenerate

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	bank_state_s state_q;
	bank_state_s state_d;
	logic [15:0] index_port;
	logic [15:0] data_port;
	logic at_index;
	logic at_data;
	logic in_config;
	logic [1:0] cur_bank;
	logic [3:0] reset_class;
	logic hard_event;
	logic soft_req;
	logic [7:0] read_val;

	// which bank the selected device number reaches in a map
	function automatic logic [1:0] bank_of(
		input logic [7:0] ldn,
		input logic numsel
	);
		logic [7:0] fl;
		logic [7:0] pp;
		fl = numsel ? FLOPPY_LDN_MAP1 : FLOPPY_LDN_MAP0;
		pp = numsel ? PARPORT_LDN_MAP1 : PARPORT_LDN_MAP0;
		if (ldn == fl)
		begin
			bank_of = BANK_FLOPPY;
		end
		else if (ldn == pp)
		begin
			bank_of = BANK_PARPORT;
		end
		else
		begin
			bank_of = BANK_NONE;
		end
	endfunction

	// ----------------------------------------------------------------
	// port decode
	// ----------------------------------------------------------------
	// port base comes from the two relocation bytes
	assign index_port = {state_q.regs[SLOT_PORT_HIGH],
		state_q.regs[SLOT_PORT_LOW]};
	assign data_port = index_port + DATA_PORT_STEP;
	assign at_index = io_req.addr == index_port;
	assign at_data = io_req.addr == data_port;
	assign in_config = state_q.mode == CONFIG_STATE;

	// global indices ignore the device number; others use the map
	always_comb
	begin
		if (state_q.index < IDX_FIRST_LOCAL)
		begin
			cur_bank = BANK_GLOBAL;
		end
		else
		begin
			cur_bank = bank_of(state_q.regs[SLOT_LDN],
				state_q.regs[SLOT_TEST_SEVEN][NUMSEL_BIT]);
		end
	end

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	// fixed and reserved indices first, then the table
	always_comb
	begin
		read_val = 8'h00;
		case (state_q.index)
			IDX_CHIP_ID:
			begin
				read_val = CHIP_ID;
			end
			IDX_CHIP_REV:
			begin
				read_val = CHIP_REV;
			end
			IDX_RSVD_A, IDX_RSVD_B, IDX_CFG_CTRL:
			begin
				read_val = 8'h00;
			end
			default:
			begin
				for (int i = 0; i < NREG; i++)
				begin
					if (REG_IDX[i] == state_q.index
						&& REG_BANK[i] == cur_bank)
					begin
						read_val = state_q.regs[i];
					end
				end
			end
		endcase
	end

	// ----------------------------------------------------------------
	// reset events
	// ----------------------------------------------------------------
	// class bits follow the table columns {bus, main, standby, soft}
	always_comb
	begin
		soft_req = io_req.wr && at_data && in_config
			&& state_q.index == IDX_CFG_CTRL
			&& io_req.wdata[SOFT_RESET_BIT];
		reset_class = {!host_bus_reset_n,
			main_supply_power_on_reset,
			standby_supply_power_on_reset,
			soft_req};
		hard_event = !host_bus_reset_n || main_supply_power_on_reset;
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		state_d = state_q;
		state_d.rsp.valid = 1'b0;

		// index port: keys and index loads
		if (io_req.wr && at_index)
		begin
			if (!in_config)
			begin
				if (io_req.wdata == KEY_ENTER)
				begin
					state_d.mode = CONFIG_STATE;
				end
			end
			else if (io_req.wdata == KEY_EXIT)
			begin
				state_d.mode = RUN_STATE;
			end
			else
			begin
				state_d.index = io_req.wdata;
			end
		end

		// data port writes, only while configuring; the control index
		// and the fixed and reserved indices match no slot
		if (io_req.wr && at_data && in_config)
		begin
			for (int i = 0; i < NREG; i++)
			begin
				if (REG_IDX[i] == state_q.index
					&& REG_BANK[i] == cur_bank)
				begin
					state_d.regs[i] = io_req.wdata;
				end
			end
			// strap-owned bit survives any write
			state_d.regs[SLOT_TEST_SEVEN][NUMSEL_BIT] =
				state_q.regs[SLOT_TEST_SEVEN][NUMSEL_BIT];
		end

		// reads: index port echoes, data port returns the register
		if (io_req.rd && in_config && (at_index || at_data))
		begin
			state_d.rsp.valid = 1'b1;
			state_d.rsp.rdata = at_index ? state_q.index : read_val;
		end

		// per-register reset columns; reset beats a same-cycle write
		for (int i = 0; i < NREG; i++)
		begin
			if (!rst_n || |(REG_RST[i] & reset_class))
			begin
				state_d.regs[i] = REG_INIT[i];
			end
		end

		// numbering bit is re-sampled from the strap on every reset except soft reset
		if (!rst_n || hard_event || standby_supply_power_on_reset)
		begin
			state_d.regs[SLOT_TEST_SEVEN][NUMSEL_BIT] =
				numbering_strap;
		end

		// hard resets return the port logic to run state
		if (!rst_n || hard_event)
		begin
			state_d.mode = RUN_STATE;
			state_d.index = 8'h00;
		end

		if (!rst_n)
		begin
			state_d.rsp = '0;
		end
	end

	// ----------------------------------------------------------------
	// register stage
	// ----------------------------------------------------------------
	// clock enable freezes all state; only rst_n is taken regardless
	always_ff @(posedge mclk)
	begin
		if (!rst_n || ce)
		begin
			state_q <= state_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign io_rsp = state_q.rsp;
	assign config_mode = in_config;
	assign device_numbering_select =
		state_q.regs[SLOT_TEST_SEVEN][NUMSEL_BIT];
	assign cfg_port_base = index_port;
	assign floppy_base = {state_q.regs[SLOT_FLOPPY_BHI],
		state_q.regs[SLOT_FLOPPY_BLO]};
	assign parport_base = {state_q.regs[SLOT_PARPORT_BHI],
		state_q.regs[SLOT_PARPORT_BLO]};
	assign floppy_active = state_q.regs[SLOT_FLOPPY_ACT][ACTIVATE_BIT];
	assign parport_active = state_q.regs[SLOT_PARPORT_ACT][ACTIVATE_BIT];

endmodule

`default_nettype wire

// ---- hw/pnp_cfg_pkg.sv ----
// constants, tables and types of the plug-and-play configuration bank
// Functional notes
// - numbering select bit lives in global 0x29
// - numbering select bit reloads from the strap on non-soft resets
// - select bit picks one of two device maps
// - 0x26 loads 0x2E on bus/main resets
// - 0x27 clears on bus/main resets only
// - indices 0x03 and 0x23 read as zero
// - identifier 0x20 and revision 0x21 hard wired
// - floppy base resets 0x03/0xF0 on all resets
// - parport mode two ignores soft reset
// - index port then data port one above
// - control bit 0 write starts soft reset
package pnp_cfg_pkg;

	// ----------------------------------------------------------------
	// keys, fixed indices and fields
	// ----------------------------------------------------------------
	localparam logic [7:0] KEY_ENTER = 8'h55;
	localparam logic [7:0] KEY_EXIT = 8'hAA;
	localparam logic [15:0] DATA_PORT_STEP = 16'h0001;
	localparam logic [7:0] IDX_CFG_CTRL = 8'h02;
	localparam logic [7:0] IDX_RSVD_A = 8'h03;
	localparam logic [7:0] IDX_CHIP_ID = 8'h20;
	localparam logic [7:0] IDX_CHIP_REV = 8'h21;
	localparam logic [7:0] IDX_RSVD_B = 8'h23;
	localparam logic [7:0] IDX_FIRST_LOCAL = 8'h30;
	localparam int SOFT_RESET_BIT = 0;
	localparam int NUMSEL_BIT = 0;
	localparam int ACTIVATE_BIT = 0;

	// device numbers of the two maps
	localparam logic [7:0] FLOPPY_LDN_MAP0 = 8'h00;
	localparam logic [7:0] PARPORT_LDN_MAP0 = 8'h01;
	localparam logic [7:0] FLOPPY_LDN_MAP1 = 8'h00;
	localparam logic [7:0] PARPORT_LDN_MAP1 = 8'h03;

	// ----------------------------------------------------------------
	// register table; reset class bits {bus, main, standby, soft}
	// ----------------------------------------------------------------
	localparam int NREG = 30;
	localparam logic [1:0] BANK_GLOBAL = 2'h0;
	localparam logic [1:0] BANK_FLOPPY = 2'h1;
	localparam logic [1:0] BANK_PARPORT = 2'h2;
	localparam logic [1:0] BANK_NONE = 2'h3;
	localparam logic [3:0] RC_ALL = 4'hF;
	localparam logic [3:0] RC_NO_SOFT = 4'hE;
	localparam logic [3:0] RC_HARD = 4'hC;
	localparam logic [3:0] RC_POWER = 4'h6;

	localparam int SLOT_LDN = 0;
	localparam int SLOT_PORT_LOW = 3;
	localparam int SLOT_PORT_HIGH = 4;
	localparam int SLOT_TEST_SEVEN = 6;
	localparam int SLOT_FLOPPY_ACT = 13;
	localparam int SLOT_FLOPPY_BHI = 14;
	localparam int SLOT_FLOPPY_BLO = 15;
	localparam int SLOT_PARPORT_ACT = 23;
	localparam int SLOT_PARPORT_BHI = 24;
	localparam int SLOT_PARPORT_BLO = 25;

	localparam logic [7:0] REG_IDX [NREG] = '{
		8'h07, 8'h22, 8'h24, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2A,
		8'h2B, 8'h2C, 8'h2D, 8'h2E, 8'h2F,
		8'h30, 8'h60, 8'h61, 8'h70, 8'h74, 8'hF0, 8'hF1, 8'hF2,
		8'hF4, 8'hF8,
		8'h30, 8'h60, 8'h61, 8'h70, 8'h74, 8'hF0, 8'hF1};

	localparam logic [1:0] REG_BANK [NREG] = '{
		2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0,
		2'h0, 2'h0, 2'h0, 2'h0, 2'h0,
		2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1,
		2'h1, 2'h1,
		2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2};

	localparam logic [7:0] REG_INIT [NREG] = '{
		8'h00, 8'h00, 8'h44, 8'h2E, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h03, 8'hF0, 8'h06, 8'h02, 8'h0E, 8'h00, 8'hFF,
		8'h00, 8'h24,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h3C, 8'h00};

	localparam logic [3:0] REG_RST [NREG] = '{
		RC_ALL, RC_ALL, RC_NO_SOFT, RC_HARD, RC_HARD, RC_POWER,
		RC_NO_SOFT, RC_POWER, RC_POWER, RC_POWER, RC_POWER,
		RC_POWER, RC_POWER,
		RC_ALL, RC_ALL, RC_ALL, RC_ALL, RC_ALL, RC_NO_SOFT,
		RC_NO_SOFT, RC_NO_SOFT, RC_NO_SOFT, RC_NO_SOFT,
		RC_ALL, RC_ALL, RC_ALL, RC_ALL, RC_ALL, RC_NO_SOFT,
		RC_NO_SOFT};

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic {RUN_STATE, CONFIG_STATE} cfg_state_e;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} io_req_s;

	typedef struct packed {
		logic [7:0] rdata;
		logic valid;
	} io_rsp_s;

	typedef struct packed {
		cfg_state_e mode;
		logic [7:0] index;
		logic [NREG-1:0][7:0] regs;
		io_rsp_s rsp;
	} bank_state_s;

endpackage

// ---- verification/pnp_config_bank_sva.sv ----
// assertion checker of the configuration bank ports
`timescale 1ns/100ps
`default_nettype none

module pnp_config_bank_sva
	import pnp_cfg_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic host_bus_reset_n,
	input wire logic main_supply_power_on_reset,
	input wire logic standby_supply_power_on_reset,
	input wire logic numbering_strap,
	input wire io_req_s io_req,
	input wire io_rsp_s io_rsp,
	input wire logic config_mode,
	input wire logic device_numbering_select,
	input wire logic [15:0] cfg_port_base,
	input wire logic [15:0] floppy_base
);
	// reset groups and port hits seen at the pins
	wire logic hard = !host_bus_reset_n || main_supply_power_on_reset;
	wire logic side = ce && (hard || standby_supply_power_on_reset);
	wire logic calm = ce && !side;
	wire logic at_idx = io_req.addr == cfg_port_base;
	wire logic at_dat = io_req.addr == cfg_port_base + 16'h0001;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// key writes at the index port
	sequence s_enter;
		calm && !config_mode && io_req.wr && at_idx
			&& io_req.wdata == 8'h55;
	endsequence
	sequence s_exit;
		calm && config_mode && io_req.wr && at_idx
			&& io_req.wdata == 8'hAA;
	endsequence

	strap_copy_a: assert property (
		side |=> device_numbering_select == $past(numbering_strap))
		else $error("numbering bit not taken from strap");
	numsel_hold_a: assert property (
		calm |=> $stable(device_numbering_select))
		else $error("numbering bit moved without reset");
	base_hard_a: assert property (
		ce && hard |=> cfg_port_base == 16'h002E)
		else $error("port base not reloaded");
	floppy_rst_a: assert property (
		side |=> floppy_base == 16'h03F0)
		else $error("floppy base not reloaded");
	enter_key_a: assert property (
		s_enter |=> config_mode)
		else $error("enter key not honoured");
	exit_key_a: assert property (
		s_exit |=> !config_mode)
		else $error("exit key not honoured");
	run_silent_a: assert property (
		calm && !config_mode && io_req.rd |=> !io_rsp.valid)
		else $error("answer given in run state");
	read_answer_a: assert property (
		calm && config_mode && io_req.rd && (at_idx || at_dat)
			|=> io_rsp.valid)
		else $error("port read not answered");
endmodule

bind pnp_config_bank pnp_config_bank_sva u_pnp_config_bank_sva (.*);

`default_nettype wire

// ---- verification/pnp_host.sv ----
// host model driving the index and data ports
`timescale 1ns/100ps
`default_nettype none

module pnp_host
	import pnp_cfg_pkg::*;
(
	input wire logic mclk,
	input wire io_rsp_s io_rsp,
	output var io_req_s io_req
);
	logic [15:0] port = 16'h002E; // current index port address

	initial io_req = '0;

	// one bus cycle; released address and data show the inverse value, strobes go low
	task automatic cyc(input logic [15:0] a, input logic [7:0] v,
		input logic w);
		@(posedge mclk);
		io_req <= '{a, v, w, !w};
		@(posedge mclk);
		io_req <= '{~a, ~v, 1'b0, 1'b0};
		#1;
	endtask

	// key byte to the index port
	task automatic key(input logic [7:0] v);
		cyc(port, v, 1'b1);
	endtask

	// index first, then data one above
	task automatic put(input logic [7:0] i, input logic [7:0] v);
		cyc(port, i, 1'b1);
		cyc(port + 16'h0001, v, 1'b1);
	endtask

	// indexed read; ok tells whether an answer came
	task automatic get(input logic [7:0] i, output logic [7:0] v,
		output logic ok);
		cyc(port, i, 1'b1);
		cyc(port + 16'h0001, 8'h00, 1'b0);
		ok = 1'b0;
		v = 8'h00;
		repeat (2)
		begin
			@(posedge mclk);
			if (!ok && io_rsp.valid === 1'b1)
			begin
				ok = 1'b1;
				v = io_rsp.rdata;
			end
		end
	endtask
endmodule

`default_nettype wire

// ---- verification/pnp_config_bank_test.sv ----
// self-checking bench of the configuration bank
`timescale 1ns/100ps
`default_nettype none

module pnp_config_bank_test;
	import pnp_cfg_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	logic hbr_n = 1'b1;
	logic mpor = 1'b0;
	logic spor = 1'b0;
	logic strap = 1'b0;
	io_req_s io_req;
	io_rsp_s io_rsp;
	logic cm, dns, pa, fa, ok;
	logic [15:0] cpb, fb, pb;
	logic [7:0] d;
	int n_fail = 0;
	int n_checks = 0;
	int cyc_n = 0;

	always #20 mclk = ~mclk;

	// identity values are arbitrary
	pnp_config_bank #(.CHIP_ID(8'h3C), .CHIP_REV(8'h07)) u_pnp_config_bank (
		.mclk(mclk), .rst_n(rst_n), .ce(ce), .host_bus_reset_n(hbr_n),
		.main_supply_power_on_reset(mpor),
		.standby_supply_power_on_reset(spor), .numbering_strap(strap),
		.io_req(io_req), .io_rsp(io_rsp), .config_mode(cm),
		.device_numbering_select(dns), .cfg_port_base(cpb),
		.floppy_base(fb), .parport_base(pb), .floppy_active(fa),
		.parport_active(pa));
	pnp_host u_pnp_host (.mclk(mclk), .io_rsp(io_rsp), .io_req(io_req));

	// compare and count
	task chk(input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e)
		begin
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
			n_fail++;
		end
	endtask

	// one-cycle side reset: 0 bus, 1 main supply, 2 standby
	task pulse(input int k, input logic s);
		@(posedge mclk);
		hbr_n <= (k != 0);
		mpor <= (k == 1);
		spor <= (k == 2);
		strap <= s;
		@(posedge mclk);
		hbr_n <= 1'b1;
		mpor <= 1'b0;
		spor <= 1'b0;
		#1;
	endtask

	task print_verdict;
		if (n_fail == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// hard-wired and reserved indices shrug off writes
	task t_fixed;
		logic [7:0] idx [4] = '{8'h20, 8'h21, 8'h03, 8'h23};
		logic [7:0] exp [4] = '{8'h3C, 8'h07, 8'h00, 8'h00};
		u_pnp_host.key(8'h55);
		chk(cpb, 16'h002E);
		for (int i = 0; i < 4; i++)
		begin
			u_pnp_host.put(idx[i], 8'hFF);
			u_pnp_host.get(idx[i], d, ok);
			chk({7'h00, ok, d}, {7'h00, 1'b1, exp[i]});
		end
	endtask

	// relocated port survives standby and soft reset, not bus reset
	task t_reloc;
		u_pnp_host.put(8'h07, 8'h00);
		u_pnp_host.put(8'h26, 8'h40);
		u_pnp_host.port = 16'h0040;
		u_pnp_host.put(8'h27, 8'h01);
		u_pnp_host.port = 16'h0140;
		chk(cpb, 16'h0140);
		pulse(2, 1'b0);
		chk(cpb, 16'h0140);
		u_pnp_host.put(8'h60, 8'h12);
		chk(fb, 16'h12F0);
		u_pnp_host.put(8'h30, 8'h01);
		chk(16'(fa), 16'h0001);
		u_pnp_host.put(8'h02, 8'h01);
		chk(cpb, 16'h0140);
		chk(fb, 16'h03F0);
		chk(16'(fa), 16'h0000);
		pulse(0, 1'b0);
		u_pnp_host.port = 16'h002E;
		chk({cm, cpb[14:0]}, 16'h002E);
	endtask

	// second mode register: soft reset keeps it, standby clears it
	task t_parport;
		u_pnp_host.key(8'h55);
		u_pnp_host.put(8'h07, 8'h01);
		u_pnp_host.put(8'hF1, 8'h77);
		u_pnp_host.put(8'h02, 8'h01);
		u_pnp_host.put(8'h07, 8'h01);
		u_pnp_host.get(8'hF1, d, ok);
		chk(16'(d), 16'h0077);
		pulse(2, 1'b0);
		u_pnp_host.put(8'h07, 8'h01);
		u_pnp_host.get(8'hF1, d, ok);
		chk(16'(d), 16'h0000);
	endtask

	// clock enable low freezes writes; parport base lands after
	task t_freeze;
		u_pnp_host.put(8'h07, 8'h01);
		u_pnp_host.put(8'h60, 8'h12);
		chk(pb, 16'h1200);
		@(posedge mclk);
		ce <= 1'b0;
		u_pnp_host.put(8'h61, 8'h34);
		chk(pb, 16'h1200);
		@(posedge mclk);
		ce <= 1'b1;
		u_pnp_host.put(8'h61, 8'h34);
		chk(pb, 16'h1234);
	endtask

	// strap picks the map; exit key silences the ports
	task t_number;
		pulse(1, 1'b1);
		chk(16'(dns), 16'h0001);
		u_pnp_host.key(8'h55);
		u_pnp_host.put(8'h29, 8'h00);
		u_pnp_host.get(8'h29, d, ok);
		chk(16'(d[0]), 16'h0001);
		u_pnp_host.put(8'h07, 8'h03);
		u_pnp_host.put(8'h30, 8'h01);
		chk(16'(pa), 16'h0001);
		u_pnp_host.put(8'h07, 8'h01);
		u_pnp_host.put(8'h30, 8'h00);
		chk(16'(pa), 16'h0001);
		u_pnp_host.key(8'hAA);
		u_pnp_host.get(8'h20, d, ok);
		chk({ok, 14'h0000, cm}, 16'h0000);
	endtask

	// hang guard
	always @(posedge mclk)
	begin
		cyc_n++;
		if (cyc_n == 4000)
		begin
			n_fail++;
			print_verdict();
		end
	end

	// main sequence
	initial
	begin
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		t_fixed();
		t_reloc();
		t_parport();
		t_freeze();
		t_number();
		print_verdict();
	end
endmodule

`default_nettype wire
